// [rtl/pbl_pkg.sv]
// Package for the self-test, loopback and test status block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package pbl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  REG_RX_ERR_IDX   = 8'h15;
  localparam logic [7:0]  REG_SELFTEST_IDX = 8'h16;
  localparam logic [7:0]  REG_STATUS_IDX   = 8'h17;
  localparam logic [9:0]  ADDR_RX_ERR      = {REG_RX_ERR_IDX, 2'b00};
  localparam logic [9:0]  ADDR_SELFTEST    = {REG_SELFTEST_IDX, 2'b00};
  localparam logic [9:0]  ADDR_STATUS      = {REG_STATUS_IDX, 2'b00};
  localparam logic [15:0] TALLY_MAX        = 16'hFFFF;
  localparam logic [15:0] CTRL_RESET       = 16'h0000;
  localparam logic [15:0] CTRL_WMASK       = 16'hF0FF;
  localparam int          BIT_CONT         = 15;
  localparam int          BIT_RAND         = 14;
  localparam int          BIT_SHORT        = 13;
  localparam int          BIT_GEN_EN       = 12;
  localparam int          BIT_REV_FWD      = 7;
  localparam int          BIT_MII_FWD      = 6;
  localparam int          LOOP_MSB         = 5;
  localparam int          LOOP_LSB         = 2;
  localparam int          ST_LOCK          = 11;
  localparam int          ST_LOST          = 10;
  localparam int          ST_BUSY          = 9;
  localparam int          ST_LEG_M         = 8;
  localparam int          ST_LEG_S         = 7;
  localparam int          ST_PWR           = 6;
  localparam logic [3:0]  LOOP_REVERSE     = 4'h8;
  localparam logic [3:0]  LOOP_EXTERNAL    = 4'h4;
  localparam logic [3:0]  LOOP_ANALOG      = 4'h2;
  localparam logic [3:0]  LOOP_DIGITAL     = 4'h1;
  localparam logic [1:0]  PCS_AFTER_MLT3   = 2'h3;
  localparam logic [1:0]  PCS_AFTER_SCR    = 2'h2;
  localparam logic [1:0]  PCS_BEFORE_SCR   = 2'h1;
  localparam logic [10:0] LEN_SHORT        = 11'h040;
  localparam logic [10:0] LEN_LONG         = 11'h5EE;
  localparam logic [15:0] PRBS_SEED        = 16'h0001;
  localparam logic [7:0]  FILL_BYTE        = 8'hA5;
  typedef enum logic [1:0] {PBL_IDLE, PBL_SEND, PBL_GAP} pbl_gen_t;
endpackage

// [rtl/pbl_selftest.sv]
// Self-test, loopback selection and test status registers of a PHY core.
// Assumes one 100 MHz clock, synchronous reset, data paths already
// on this clock, and a classic Wishbone master for register access.
//
// Function
// - Sixteen-bit receive error tally saturates at FFFF, never wraps.
// - Any write to the error tally register clears it.
// - Continuous mode: counter at maximum pulses once and restarts at zero.
// - Random payload off with generator on sends one constant packet only.
// - Short packet select gives 64-byte packets, otherwise 1518-byte.
// - Generator enable bit switches the generator on and off.
// - Reverse forward bit only in reverse loop; sends received data to MAC.
// - MII forward bit only in MII loop; enables line transmit.
// - Loop point field is one-hot: reverse, external, analog, digital.
// - Fast Ethernet coding loop: 11 after MLT3, 10 after scrambler, 01 before.
// - Gigabit: any coding loop value with low bit set loops early.
// - Status bit 11 shows checker lock.
// - Status bit 10 latches lock loss until read, clears on read.
// - Status bit 9 shows generator activity.
// - Status bits 8 and 7 show legacy encoding of master and slave.
// - Status bit 6 shows normal core power.
// - Reserved bits ignore writes and read zero.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pbl_selftest
  import pbl_pkg::*;
#(
  parameter int LEN_W = 11
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        rx_error_i,
  input  wire logic        rx_byte_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        gig_mode_i,
  input  wire logic        legacy_master_i,
  input  wire logic        legacy_slave_i,
  input  wire logic        core_power_normal_i,
  input  wire logic        mii_loop_i,
  output logic             gen_valid_o,
  output logic      [7:0]  gen_byte_o,
  output logic             gen_last_o,
  output logic             prbs_wrap_o,
  output logic      [3:0]  loop_point_o,
  output logic             fast_loop_after_mlt3_o,
  output logic             fast_loop_after_scr_o,
  output logic             fast_loop_before_scr_o,
  output logic             gig_loop_early_o,
  output logic             rx_to_mac_en_o,
  output logic             tx_to_line_en_o
);

  // ********************************************************************
  // Register bus
  // ********************************************************************
  logic        req;
  logic        wr;
  logic        rd;
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [15:0] tally;
  logic [15:0] next_tally;
  logic        lost;
  logic        next_lost;
  logic        locked;
  logic        next_locked;
  logic        busy;
  logic        gen_on;
  logic        chk_on;
  logic [15:0] status_word;
  logic [31:0] next_dat;
  logic        next_ack;

  // Single-cycle answer; ack drops the cycle after it was given
  assign req = cyc_i && stb_i && !ack_o;
  assign wr  = req && we_i;
  assign rd  = req && !we_i;

  assign status_word = {4'h0, locked, lost, busy,
                        legacy_master_i, legacy_slave_i,
                        core_power_normal_i, 6'h00};

  always_comb begin
    next_ack = req;
    next_dat = 32'h0000_0000;
    if (rd) begin
      unique case (adr_i)
        ADDR_RX_ERR:   next_dat = {16'h0000, tally};
        ADDR_SELFTEST: next_dat = {16'h0000, ctrl};
        ADDR_STATUS:   next_dat = {16'h0000, status_word};
        default:       next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    if (wr && adr_i == ADDR_SELFTEST) begin
      if (sel_i[0]) next_ctrl[7:0] = dat_i[7:0] & CTRL_WMASK[7:0];
      if (sel_i[1]) next_ctrl[15:8] = dat_i[15:8] & CTRL_WMASK[15:8];
    end
    // Forward bits only stick in the loop they belong to
    if (next_ctrl[LOOP_MSB:LOOP_LSB] != LOOP_REVERSE)
      next_ctrl[BIT_REV_FWD] = 1'b0;
    if (!mii_loop_i)
      next_ctrl[BIT_MII_FWD] = 1'b0;
  end

  // ********************************************************************
  // Receive error tally
  // ********************************************************************
  always_comb begin
    next_tally = tally;
    if (wr && adr_i == ADDR_RX_ERR)
      next_tally = 16'h0000;
    else if (rx_error_i && tally != TALLY_MAX)
      next_tally = tally + 16'h0001;
  end

  // ********************************************************************
  // Packet and PRBS generator
  // ********************************************************************
  pbl_gen_t    state;
  pbl_gen_t    next_state;
  logic [LEN_W-1:0] cnt;
  logic [LEN_W-1:0] next_cnt;
  logic [LEN_W-1:0] pkt_len;
  logic [15:0] lfsr;
  logic [15:0] next_lfsr;
  logic        next_valid;
  logic [7:0]  next_byte;
  logic        next_last;
  logic        next_wrap;
  logic        one_shot_done;
  logic        next_one_shot;

  assign gen_on = ctrl[BIT_GEN_EN];
  // Checker runs only with random payload and continuous mode, as software must set both
  assign chk_on = ctrl[BIT_RAND] && ctrl[BIT_CONT];
  assign pkt_len = ctrl[BIT_SHORT] ? LEN_SHORT[LEN_W-1:0]
                                   : LEN_LONG[LEN_W-1:0];
  assign busy = (state == PBL_SEND);

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_lfsr     = lfsr;
    next_valid    = 1'b0;
    next_byte     = 8'h00;
    next_last     = 1'b0;
    next_wrap     = 1'b0;
    next_one_shot = one_shot_done;
    if (!gen_on) next_one_shot = 1'b0;
    unique case (state)
      PBL_IDLE: begin
        // A constant packet goes out once per enable
        if (gen_on && (ctrl[BIT_RAND] || !one_shot_done)) begin
          next_state = PBL_SEND;
          next_cnt   = '0;
        end
      end
      PBL_SEND: begin
        next_valid = 1'b1;
        next_byte  = ctrl[BIT_RAND] ? lfsr[7:0] : FILL_BYTE;
        // Sequence only steps on random payload, so it stays in step
        // with the checker, which steps only on checked bytes
        if (ctrl[BIT_RAND])
          next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[14] ^ lfsr[12] ^ lfsr[3]};
        next_cnt   = cnt + 1'b1;
        if (cnt == pkt_len - 1'b1) begin
          next_last  = 1'b1;
          next_state = PBL_GAP;
          if (!ctrl[BIT_RAND]) next_one_shot = 1'b1;
        end
        if (!gen_on) next_state = PBL_IDLE;
      end
      PBL_GAP: begin
        // Back-to-back: one idle cycle then the next packet
        next_state = (gen_on && ctrl[BIT_RAND]) ? PBL_SEND : PBL_IDLE;
        next_cnt   = '0;
      end
    endcase
    // Byte counter restarts from zero with a pulse in continuous mode
    if (ctrl[BIT_CONT] && state == PBL_SEND && cnt == pkt_len - 1'b1)
      next_wrap = 1'b1;
  end

  // ********************************************************************
  // PRBS checker
  // ********************************************************************
  logic [15:0] chk_lfsr;
  logic [15:0] next_chk_lfsr;
  logic [15:0] exp_word;

  assign exp_word = {chk_lfsr[14:0],
                     chk_lfsr[15] ^ chk_lfsr[14] ^ chk_lfsr[12] ^ chk_lfsr[3]};

  always_comb begin
    next_chk_lfsr = chk_lfsr;
    next_locked   = locked;
    next_lost     = lost;
    if (rd && adr_i == ADDR_STATUS) next_lost = 1'b0;
    if (!chk_on) begin
      next_locked = 1'b0;
    end else if (rx_byte_valid_i) begin
      next_chk_lfsr = exp_word;
      if (rx_byte_i == chk_lfsr[7:0]) begin
        next_locked = 1'b1;
      end else begin
        // Keep stepping past a bad byte so one error relocks at once;
        // limitation: the stream must start from the seed to lock
        next_locked   = 1'b0;
        if (locked) next_lost = 1'b1;
      end
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl          <= CTRL_RESET;
      tally         <= 16'h0000;
      lost          <= 1'b0;
      locked        <= 1'b0;
      ack_o         <= 1'b0;
      dat_o         <= 32'h0000_0000;
      state         <= PBL_IDLE;
      cnt           <= '0;
      lfsr          <= PRBS_SEED;
      chk_lfsr      <= PRBS_SEED;
      one_shot_done <= 1'b0;
      gen_valid_o   <= 1'b0;
      gen_byte_o    <= 8'h00;
      gen_last_o    <= 1'b0;
      prbs_wrap_o   <= 1'b0;
    end else begin
      ctrl          <= next_ctrl;
      tally         <= next_tally;
      lost          <= next_lost;
      locked        <= next_locked;
      ack_o         <= next_ack;
      dat_o         <= next_dat;
      state         <= next_state;
      cnt           <= next_cnt;
      lfsr          <= next_lfsr;
      chk_lfsr      <= next_chk_lfsr;
      one_shot_done <= next_one_shot;
      gen_valid_o   <= next_valid;
      gen_byte_o    <= next_byte;
      gen_last_o    <= next_last;
      prbs_wrap_o   <= next_wrap;
    end
  end

  // ********************************************************************
  // Loopback steering
  // ********************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_point_o           <= 4'h0;
      fast_loop_after_mlt3_o <= 1'b0;
      fast_loop_after_scr_o  <= 1'b0;
      fast_loop_before_scr_o <= 1'b0;
      gig_loop_early_o       <= 1'b0;
      rx_to_mac_en_o         <= 1'b1;
      tx_to_line_en_o        <= 1'b1;
    end else begin
      // Only legal one-hot codes reach the datapath
      unique case (ctrl[LOOP_MSB:LOOP_LSB])
        LOOP_REVERSE, LOOP_EXTERNAL, LOOP_ANALOG, LOOP_DIGITAL:
          loop_point_o <= ctrl[LOOP_MSB:LOOP_LSB];
        default: loop_point_o <= 4'h0;
      endcase
      fast_loop_after_mlt3_o <= !gig_mode_i && ctrl[1:0] == PCS_AFTER_MLT3;
      fast_loop_after_scr_o  <= !gig_mode_i && ctrl[1:0] == PCS_AFTER_SCR;
      fast_loop_before_scr_o <= !gig_mode_i
                                && ctrl[1:0] == PCS_BEFORE_SCR;
      gig_loop_early_o       <= gig_mode_i && ctrl[0];
      rx_to_mac_en_o  <= (ctrl[LOOP_MSB:LOOP_LSB] != LOOP_REVERSE)
                         || ctrl[BIT_REV_FWD];
      tx_to_line_en_o <= !mii_loop_i || ctrl[BIT_MII_FWD];
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  a_tally_saturates: assert property (@(posedge clk_i) disable iff (rst_i)
    tally == TALLY_MAX && !(wr && adr_i == ADDR_RX_ERR) |=> tally == TALLY_MAX)
    else $error("error tally wrapped");
  a_tally_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == ADDR_RX_ERR |=> tally == 16'h0000)
    else $error("error tally not cleared by write");
  a_tally_counts: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_error_i && !wr && tally != TALLY_MAX |=> tally == $past(tally) + 16'h0001)
    else $error("error tally missed an event");
  a_lost_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
    locked && !next_locked && chk_on
    |=> lost ##1 (lost || $past(rd && adr_i == ADDR_STATUS)))
    else $error("lock loss flag not held");
  a_busy_sends: assert property (@(posedge clk_i) disable iff (rst_i)
    busy && gen_on |=> gen_valid_o)
    else $error("busy without generated data");
  a_gen_off_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !gen_on [*2] |=> !busy)
    else $error("generator runs while disabled");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[11:8] == 4'h0 && status_word[15:12] == 4'h0)
    else $error("reserved bits not zero");
  a_rev_forward: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[LOOP_MSB:LOOP_LSB] == LOOP_REVERSE && !ctrl[BIT_REV_FWD]
    |=> !rx_to_mac_en_o)
    else $error("receive data leaked to MAC in reverse loop");
  a_gig_loop: assert property (@(posedge clk_i) disable iff (rst_i)
    gig_mode_i && ctrl[0] |=> gig_loop_early_o && !fast_loop_before_scr_o)
    else $error("gigabit early loop not selected");
  a_wrap_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    state == PBL_SEND && cnt == pkt_len - 1'b1 && ctrl[BIT_CONT]
    |=> prbs_wrap_o && gen_last_o)
    else $error("continuous mode pulse missing");
  a_one_packet: assert property (@(posedge clk_i) disable iff (rst_i)
    gen_last_o && !ctrl[BIT_RAND] && gen_on |=> !busy ##1 !busy)
    else $error("constant packet repeated");
  a_loop_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(loop_point_o))
    else $error("loop point not one-hot");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// [tb/pbl_mac_model.sv]
// MAC-side model: feeds the generated byte stream back to the checker.
// Assumes generator outputs and checker inputs share clk_i.
`timescale 1ns/1ps
`default_nettype none
module pbl_mac_model (
  input  wire logic       clk_i,
  input  wire logic       gen_valid_i,
  input  wire logic [7:0] gen_byte_i,
  input  wire logic       corrupt_i,
  output logic            rx_byte_valid_o,
  output logic      [7:0] rx_byte_o
);
  initial rx_byte_valid_o = 1'b0;
  initial rx_byte_o = 8'h00;
  // Each idle cycle inverts the held byte, so it alternates with its inverse;
  // valid stays low, so stale data can never pass for a fresh match
  always_ff @(posedge clk_i) begin
    rx_byte_valid_o <= gen_valid_i;
    if (gen_valid_i)
      rx_byte_o <= corrupt_i ? ~gen_byte_i : gen_byte_i;
    else
      rx_byte_o <= ~rx_byte_o;
  end
endmodule
`default_nettype wire

// [tb/phy_bist_loopback_status_test.sv]
// Testbench for the self-test, loopback and test status block.
// Assumes the MAC model loops generator bytes into the checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module phy_bist_loopback_status_test;
  import pbl_pkg::*;
  // ****************************************
  // Stimulus, monitor and scenarios
  // ****************************************
  logic        clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wdat = 32'h0, dat_o;
  logic        ack_o, rx_err = 1'b0, gig = 1'b0, leg_m = 1'b0;
  logic        leg_s = 1'b0, pwr = 1'b0, mii = 1'b0, corrupt = 1'b0;
  logic        rx_v, gen_valid_o, gen_last_o, prbs_wrap_o;
  logic [7:0]  rx_b, gen_byte_o;
  logic [3:0]  loop_point_o;
  logic        f_mlt3, f_scr, f_pre, g_early, to_mac, to_line;
  logic [15:0] rd;
  int          error_cnt = 0, n_checks = 0;
  int          cnt = 0, plen = 0, npk = 0, wraps = 0, badfill = 0;
  always #5 clk_i = ~clk_i;
  pbl_selftest pbl_selftest_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr), .sel_i(4'h3),
    .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .rx_error_i(rx_err),
    .rx_byte_valid_i(rx_v), .rx_byte_i(rx_b), .gig_mode_i(gig),
    .legacy_master_i(leg_m), .legacy_slave_i(leg_s),
    .core_power_normal_i(pwr), .mii_loop_i(mii),
    .gen_valid_o(gen_valid_o), .gen_byte_o(gen_byte_o),
    .gen_last_o(gen_last_o), .prbs_wrap_o(prbs_wrap_o),
    .loop_point_o(loop_point_o), .fast_loop_after_mlt3_o(f_mlt3),
    .fast_loop_after_scr_o(f_scr), .fast_loop_before_scr_o(f_pre),
    .gig_loop_early_o(g_early), .rx_to_mac_en_o(to_mac),
    .tx_to_line_en_o(to_line));
  pbl_mac_model pbl_mac_model_i (.clk_i(clk_i), .gen_valid_i(gen_valid_o),
    .gen_byte_i(gen_byte_o), .corrupt_i(corrupt),
    .rx_byte_valid_o(rx_v), .rx_byte_o(rx_b));
  always @(posedge clk_i) begin
    if (gen_valid_o === 1'b1) begin
      cnt <= cnt + 1;
      if (gen_byte_o !== FILL_BYTE)
        badfill <= badfill + 1;
      if (gen_last_o === 1'b1) begin
        plen <= cnt + 1;
        cnt <= 0;
        npk <= npk + 1;
      end
    end
    if (prbs_wrap_o === 1'b1)
      wraps <= wraps + 1;
  end
  task automatic results();
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Holds the request until ack is sampled high or 20 cycles pass, then releases it
  task automatic wb(input logic w, input logic [9:0] a,
                    input logic [15:0] d);
    int t;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    for (t = 0; t < 20; t++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    `CHK("ack", 1'b1, ack_o)
    rd = dat_o[15:0];
    req <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rchk(input logic [9:0] a, input logic [15:0] e,
                      input string nm);
    wb(1'b0, a, 16'h0000);
    `CHK(nm, e, rd)
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask
  task automatic t_reset();
    rchk(ADDR_RX_ERR, 16'h0000, "tally");
    rchk(ADDR_SELFTEST, CTRL_RESET, "ctl");
    rchk(ADDR_STATUS, 16'h0000, "status");
    rchk(10'h3F0, 16'h0000, "unmapped");
    `CHK("loop", 4'h0, loop_point_o)
  endtask
  task automatic t_tally();
    rx_err <= 1'b1;
    repeat (5) @(posedge clk_i);
    rx_err <= 1'b0;
    rchk(ADDR_RX_ERR, 16'h0005, "tally");
    wb(1'b1, ADDR_RX_ERR, 16'h1234);
    rchk(ADDR_RX_ERR, 16'h0000, "tally clr");
    rx_err <= 1'b1;
    repeat (65540) @(posedge clk_i);
    rx_err <= 1'b0;
    rchk(ADDR_RX_ERR, TALLY_MAX, "tally sat");
    wb(1'b1, ADDR_RX_ERR, 16'hFFFF);
    rchk(ADDR_RX_ERR, 16'h0000, "tally clr");
  endtask
  task automatic t_status();
    leg_m <= 1'b1;
    pwr <= 1'b1;
    rchk(ADDR_STATUS, 16'h0140, "status");
    leg_m <= 1'b0;
    leg_s <= 1'b1;
    pwr <= 1'b0;
    rchk(ADDR_STATUS, 16'h0080, "status");
    wb(1'b1, ADDR_STATUS, 16'hFFFF);
    rchk(ADDR_STATUS, 16'h0080, "status ro");
    leg_s <= 1'b0;
  endtask
  task automatic t_loop();
    logic [3:0] c[4] = '{LOOP_REVERSE, LOOP_EXTERNAL, LOOP_ANALOG,
                         LOOP_DIGITAL};
    wb(1'b1, ADDR_SELFTEST, 16'h0FFF);
    rchk(ADDR_SELFTEST, 16'h003F, "ctl rsvd");
    settle();
    `CHK("loop bad", 4'h0, loop_point_o)
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ADDR_SELFTEST, 16'h0000);
      wb(1'b1, ADDR_SELFTEST, {10'h000, c[i], 2'b00});
      settle();
      `CHK("loop", c[i], loop_point_o)
    end
    wb(1'b1, ADDR_SELFTEST, 16'h00A0);
    rchk(ADDR_SELFTEST, 16'h00A0, "rev fwd");
    settle();
    `CHK("to mac", 1'b1, to_mac)
    wb(1'b1, ADDR_SELFTEST, 16'h0020);
    settle();
    `CHK("to mac", 1'b0, to_mac)
    mii <= 1'b1;
    wb(1'b1, ADDR_SELFTEST, 16'h0040);
    rchk(ADDR_SELFTEST, 16'h0040, "mii fwd");
    settle();
    `CHK("to line", 1'b1, to_line)
    wb(1'b1, ADDR_SELFTEST, 16'h0000);
    settle();
    `CHK("to line", 1'b0, to_line)
    mii <= 1'b0;
  endtask
  task automatic t_pcs();
    for (int g = 0; g < 2; g++) begin
      gig <= g[0];
      for (int p = 1; p < 4; p++) begin
        wb(1'b1, ADDR_SELFTEST, p[15:0]);
        settle();
        if (g == 0)
          `CHK("fast", {p == 3, p == 2, p == 1}, {f_mlt3, f_scr, f_pre})
        else
          `CHK("gig", p[0], g_early)
      end
    end
    wb(1'b1, ADDR_SELFTEST, 16'h0000);
    gig <= 1'b0;
  endtask
  task automatic t_gen(input logic [15:0] ctl, input int len);
    int pk0 = npk, w0 = wraps, b0 = badfill;
    wb(1'b1, ADDR_SELFTEST, ctl);
    wb(1'b0, ADDR_STATUS, 16'h0000);
    `CHK("busy", 1'b1, rd[ST_BUSY])
    for (int t = 0; t < 2000 && npk == pk0; t++) @(posedge clk_i);
    repeat (100) @(posedge clk_i);
    `CHK("packets", 1, npk - pk0)
    `CHK("length", len, plen)
    `CHK("fill", 0, badfill - b0)
    `CHK("wrap", 1, wraps - w0)
    rchk(ADDR_STATUS, 16'h0000, "idle");
    wb(1'b1, ADDR_SELFTEST, 16'h0000);
  endtask
  task automatic t_prbs();
    int pk0 = npk;
    wb(1'b1, ADDR_SELFTEST, 16'hF000);
    for (int t = 0; t < 500 && npk < pk0 + 3; t++) @(posedge clk_i);
    `CHK("b2b", 1'b1, npk >= pk0 + 3)
    wb(1'b0, ADDR_STATUS, 16'h0000);
    // Busy toggles with the gap cycle, so it is masked here
    `CHK("lock", 16'h0800, rd & 16'hFDFF)
    for (int t = 0; t < 200 && cnt != 10; t++) @(posedge clk_i);
    corrupt <= 1'b1;
    @(posedge clk_i);
    corrupt <= 1'b0;
    repeat (5) @(posedge clk_i);
    wb(1'b0, ADDR_STATUS, 16'h0000);
    `CHK("lost", 1'b1, rd[ST_LOST])
    wb(1'b0, ADDR_STATUS, 16'h0000);
    `CHK("relock", 16'h0800, rd & 16'hFDFF)
    wb(1'b1, ADDR_SELFTEST, 16'h0000);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_tally();
    t_status();
    t_loop();
    t_pcs();
    t_gen(16'hB000, 64);
    t_gen(16'h9000, 1518);
    t_prbs();
    results();
  end
  initial begin
    #950000;
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
